// *** rtl/alu_exec_core.sv ***
/*
  Execution datapath slice of an 8-bit core: subtract, nibble exchange,
  exclusive-or and sleep, with accumulator, 128 file registers, status
  flags and watchdog, reached over AXI4-Lite.
  Assumes one clock MCLK at 125 MHz, synchronous active-high RST, and an
  asynchronous WAKE pin.
*/
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "alu_exec_regs.svh"

module alu_exec_core (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // axi4-lite write address
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // power
  input  wire logic        WAKE,
  output logic             OSC_RUN,
  output logic             ASLEEP
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  file_mem [0:127];
  logic        aw_full,  next_aw_full;
  logic [11:0] aw_addr,  next_aw_addr;
  logic        w_full,   next_w_full;
  logic [31:0] w_data,   next_w_data;
  logic [3:0]  w_strb,   next_w_strb;
  logic        bvalid,   next_bvalid;
  logic [1:0]  bresp,    next_bresp;
  logic        rvalid,   next_rvalid;
  logic [31:0] rdata,    next_rdata;
  logic [1:0]  rresp,    next_rresp;
  logic [31:0] instr,    next_instr;
  logic [7:0]  acc,      next_acc;
  logic        borrow_inv, next_borrow_inv;
  logic        nib_inv,    next_nib_inv;
  logic        res_null,   next_res_null;
  logic        powerdown_flag, next_powerdown_flag;
  logic        expiry_indicator, next_expiry_indicator;
  logic [7:0]  watchdog_counter, next_watchdog_counter;
  logic [7:0]  prescale, next_prescale;
  logic [9:0]  div_cnt,  next_div_cnt;
  alu_exec_pkg::power_e pstate, next_pstate;
  logic        wake_s1, wake_s2;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic        do_write, do_read, exec, wdog_tick, wdog_over;
  logic        wr_is_file, file_we;
  logic [6:0]  file_wa;
  logic [7:0]  file_wd, fval;
  logic [6:0]  op_faddr;
  alu_exec_pkg::op_e op;
  logic [7:0]  alu_res;
  logic        alu_borrow, alu_nib, alu_null, upd_borrow, upd_null, wr_acc, wr_file;

  assign op       = alu_exec_pkg::op_e'(w_data[`INSTR_OP_MSB:0]);
  assign op_faddr = w_data[`INSTR_FADDR_MSB:`INSTR_FADDR_LSB];
  assign fval     = file_mem[op_faddr];

  alu_unit u_alu (
    .op                (op),
    .dest              (w_data[`INSTR_DEST_BIT]),
    .acc               (acc),
    .fval              (fval),
    .lit               (w_data[`INSTR_LIT_MSB:`INSTR_LIT_LSB]),
    .res               (alu_res),
    .borrow_inv        (alu_borrow),
    .nibble_borrow_inv (alu_nib),
    .result_null       (alu_null),
    .upd_borrow        (upd_borrow),
    .upd_null          (upd_null),
    .wr_acc            (wr_acc),
    .wr_file           (wr_file)
  );

  assign S_AXI_AWREADY = ~aw_full;
  assign S_AXI_WREADY  = ~w_full;
  assign S_AXI_ARREADY = ~rvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;
  assign ASLEEP        = (pstate == alu_exec_pkg::ASLEEP);
  assign OSC_RUN       = (pstate == alu_exec_pkg::AWAKE);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_instr   = instr;
    next_acc     = acc;
    next_borrow_inv       = borrow_inv;
    next_nib_inv          = nib_inv;
    next_res_null         = res_null;
    next_powerdown_flag   = powerdown_flag;
    next_expiry_indicator = expiry_indicator;
    next_watchdog_counter = watchdog_counter;
    next_prescale         = prescale;
    next_div_cnt          = div_cnt;
    next_pstate           = pstate;
    file_we = 1'b0;
    file_wa = op_faddr;
    file_wd = alu_res;

    // write channel: address and data held until both are present
    if (S_AXI_AWVALID && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    do_write   = aw_full && w_full && !bvalid;
    wr_is_file = (aw_addr[11:9] == `FILE_BASE_TOP);
    // a new instruction is refused while the core sleeps
    exec = do_write && (aw_addr == `INSTR_OFS) && (|w_strb)
           && (pstate == alu_exec_pkg::AWAKE);
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      if (wr_is_file) begin
        file_we = w_strb[0];
        file_wa = aw_addr[8:2];
        file_wd = w_data[7:0];
      end else if (aw_addr == `ACC_OFS) begin
        if (w_strb[0]) begin
          next_acc = w_data[7:0];
        end
      end else if (aw_addr != `INSTR_OFS) begin
        next_bresp = `RESP_SLVERR;
      end
    end

    // watchdog runs in sleep too, from its own tick divider
    wdog_tick = (div_cnt == 10'(`WDOG_TICK_CYC - 1));
    next_div_cnt = wdog_tick ? 10'h000 : div_cnt + 10'h001;
    wdog_over = wdog_tick && (prescale == 8'hff) && (watchdog_counter == 8'hff);
    if (wdog_tick) begin
      next_prescale = prescale + 8'h01;
      if (prescale == 8'hff) begin
        next_watchdog_counter = watchdog_counter + 8'h01;
      end
    end
    if (wdog_over) begin
      next_expiry_indicator = 1'b0;
      next_pstate           = alu_exec_pkg::AWAKE;
    end
    if (wake_s2 && pstate == alu_exec_pkg::ASLEEP) begin
      next_pstate = alu_exec_pkg::AWAKE;
    end

    if (exec) begin
      next_instr = w_data;
      if (wr_acc) begin
        next_acc = alu_res;
      end
      file_we = wr_file;
      if (upd_borrow) begin
        next_borrow_inv = alu_borrow;
        next_nib_inv    = alu_nib;
      end
      if (upd_null) begin
        next_res_null = alu_null;
      end
      if (op == alu_exec_pkg::SLEEP_OP) begin
        next_powerdown_flag   = 1'b0;
        next_expiry_indicator = 1'b1;
        next_watchdog_counter = 8'h00;
        next_prescale         = 8'h00;
        next_pstate           = alu_exec_pkg::ASLEEP;
      end
    end

    // read channel: one-cycle registered answer
    if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
    do_read = S_AXI_ARVALID && !rvalid;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (S_AXI_ARADDR[11:9] == `FILE_BASE_TOP) begin
        next_rdata[7:0] = file_mem[S_AXI_ARADDR[8:2]];
      end else begin
        case (S_AXI_ARADDR)
          `INSTR_OFS:    next_rdata = instr;
          `ACC_OFS:      next_rdata[7:0] = acc;
          `STATUS_OFS: begin
            next_rdata[`ST_BORROW_INV]    = borrow_inv;
            next_rdata[`ST_NIBBLE_BORROW] = nib_inv;
            next_rdata[`ST_RESULT_NULL]   = res_null;
            next_rdata[`ST_POWERDOWN]     = powerdown_flag;
            next_rdata[`ST_EXPIRY]        = expiry_indicator;
            next_rdata[`ST_ASLEEP]        = (pstate == alu_exec_pkg::ASLEEP);
          end
          `WATCHDOG_OFS: next_rdata[15:0] = {prescale, watchdog_counter};
          default:       next_rresp = `RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    wake_s1 <= WAKE;
    wake_s2 <= wake_s1;
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      aw_full <= 1'b0;
      aw_addr <= 12'h000;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
      instr   <= 32'h0000_0000;
      acc     <= 8'h00;
      borrow_inv       <= 1'b0;
      nib_inv          <= 1'b0;
      res_null         <= 1'b0;
      powerdown_flag   <= `POWERDOWN_RST;
      expiry_indicator <= `EXPIRY_RST;
      watchdog_counter <= 8'h00;
      prescale         <= 8'h00;
      div_cnt          <= 10'h000;
      pstate           <= alu_exec_pkg::AWAKE;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      instr   <= next_instr;
      acc     <= next_acc;
      borrow_inv       <= next_borrow_inv;
      nib_inv          <= next_nib_inv;
      res_null         <= next_res_null;
      powerdown_flag   <= next_powerdown_flag;
      expiry_indicator <= next_expiry_indicator;
      watchdog_counter <= next_watchdog_counter;
      prescale         <= next_prescale;
      div_cnt          <= next_div_cnt;
      pstate           <= next_pstate;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic [7:0] lit_now;
  logic       lit_ge;
  assign lit_now = w_data[`INSTR_LIT_MSB:`INSTR_LIT_LSB];
  assign lit_ge  = (lit_now >= acc);

  sequence s_exec(alu_exec_pkg::op_e o);
    exec && op == o;
  endsequence
  sequence s_asleep_held;
    ASLEEP && !OSC_RUN;
  endsequence

  property p_sub_file;
    s_exec(alu_exec_pkg::SUBTRACT_ACC_FROM_FILE) ##0 !w_data[`INSTR_DEST_BIT]
      |=> acc == $past(fval) - $past(acc) && borrow_inv == ($past(acc) <= $past(fval));
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("file subtract wrong");

  property p_sub_lit;
    s_exec(alu_exec_pkg::SUBTRACT_ACC_FROM_LITERAL)
      |=> acc == $past(lit_now) - $past(acc) && borrow_inv == $past(lit_ge);
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

  property p_dest_file;
    exec && wr_file |=> $stable(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("acc changed on file dest");

  property p_swap;
    s_exec(alu_exec_pkg::NIBBLE_EXCHANGE_FILE) |=> $stable(borrow_inv)
      && $stable(nib_inv) && $stable(res_null);
  endproperty
  a_swap: assert property (p_swap) else $error("swap changed flags");

  property p_xor_lit;
    s_exec(alu_exec_pkg::XOR_LITERAL_INTO_ACC)
      |=> $stable(borrow_inv) && res_null == (acc == 8'h00);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

  property p_xor_file;
    s_exec(alu_exec_pkg::XOR_ACC_WITH_FILE) |=> $stable(nib_inv)
      && res_null == (($past(acc) ^ $past(fval)) == 8'h00);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file wrong");

  property p_sleep_flags;
    s_exec(alu_exec_pkg::SLEEP_OP) |=> !powerdown_flag && expiry_indicator;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

  property p_sleep_wdt;
    s_exec(alu_exec_pkg::SLEEP_OP) |=> watchdog_counter == 8'h00 && prescale == 8'h00;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog not cleared");

  property p_sleep_halt;
    s_exec(alu_exec_pkg::SLEEP_OP) ##1 !wake_s2 |-> s_asleep_held;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sleep not entered");

  property p_no_exec_asleep;
    ASLEEP |-> !exec;
  endproperty
  a_no_exec_asleep: assert property (p_no_exec_asleep) else $error("ran while asleep");

  property p_null;
    exec && upd_null |=> res_null == ($past(alu_res) == 8'h00);
  endproperty
  a_null: assert property (p_null) else $error("null flag wrong");

endmodule

// *** rtl/alu_exec_regs.svh ***
/*
  Offsets, field positions, reset values and timing counts of the
  execution datapath block.
  Assumes a 12-bit byte address on the register bus.
*/
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define INSTR_OFS        12'h000
`define ACC_OFS          12'h004
`define STATUS_OFS       12'h008
`define WATCHDOG_OFS     12'h00c
`define FILE_BASE_TOP    3'h1

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define INSTR_OP_MSB     2
`define INSTR_DEST_BIT   3
`define INSTR_FADDR_LSB  4
`define INSTR_FADDR_MSB  10
`define INSTR_LIT_LSB    16
`define INSTR_LIT_MSB    23

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define ST_BORROW_INV    0
`define ST_NIBBLE_BORROW 1
`define ST_RESULT_NULL   2
`define ST_POWERDOWN     3
`define ST_EXPIRY        4
`define ST_ASLEEP        5

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define POWERDOWN_RST    1'b1
`define EXPIRY_RST       1'b1
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCLK_NS          8
`define WDOG_TICK_NS     1000
`define WDOG_TICK_CYC    (`WDOG_TICK_NS / `MCLK_NS)

`endif

// *** rtl/alu_exec_pkg.sv ***
/*
  Types of the execution datapath block: operation codes and power state.
  Assumes the constants header is included by the design files.
*/
package alu_exec_pkg;

  // operation field of the instruction word; codes 6 and 7 do nothing
  typedef enum logic [2:0] {
    SUBTRACT_ACC_FROM_FILE,
    SUBTRACT_ACC_FROM_LITERAL,
    NIBBLE_EXCHANGE_FILE,
    XOR_LITERAL_INTO_ACC,
    XOR_ACC_WITH_FILE,
    SLEEP_OP
  } op_e;

  typedef enum logic {
    AWAKE,
    ASLEEP
  } power_e;

endpackage

// *** rtl/alu_unit.sv ***
/*
  Combinational arithmetic for the six operations: result, flag values,
  which flags update and where the result goes.
  Assumes operands are stable for the cycle in which they are used.
*/
`timescale 1ns/1ps

module alu_unit (
  // operation
  input  wire alu_exec_pkg::op_e op,
  input  wire logic              dest,
  // operands
  input  wire logic [7:0]        acc,
  input  wire logic [7:0]        fval,
  input  wire logic [7:0]        lit,
  // answer
  output logic      [7:0]        res,
  output logic                   borrow_inv,
  output logic                   nibble_borrow_inv,
  output logic                   result_null,
  output logic                   upd_borrow,
  output logic                   upd_null,
  output logic                   wr_acc,
  output logic                   wr_file
);

  logic [7:0] minuend;
  logic [8:0] diff;
  logic [4:0] ndiff;

  always_comb begin
    minuend = (op == alu_exec_pkg::SUBTRACT_ACC_FROM_LITERAL) ? lit : fval;
    diff    = {1'b0, minuend} - {1'b0, acc};
    ndiff   = {1'b0, minuend[3:0]} - {1'b0, acc[3:0]};
    // borrow flags read 1 when no borrow occurred (acc <= minuend)
    borrow_inv        = ~diff[8];
    nibble_borrow_inv = ~ndiff[4];
    res        = 8'h00;
    upd_borrow = 1'b0;
    upd_null   = 1'b0;
    wr_acc     = 1'b0;
    wr_file    = 1'b0;
    case (op)
      alu_exec_pkg::SUBTRACT_ACC_FROM_FILE: begin
        res        = diff[7:0];
        upd_borrow = 1'b1;
        upd_null   = 1'b1;
        wr_acc     = ~dest;
        wr_file    = dest;
      end
      alu_exec_pkg::SUBTRACT_ACC_FROM_LITERAL: begin
        res        = diff[7:0];
        upd_borrow = 1'b1;
        upd_null   = 1'b1;
        wr_acc     = 1'b1;
      end
      alu_exec_pkg::NIBBLE_EXCHANGE_FILE: begin
        res     = {fval[3:0], fval[7:4]};
        wr_acc  = ~dest;
        wr_file = dest;
      end
      alu_exec_pkg::XOR_LITERAL_INTO_ACC: begin
        res      = acc ^ lit;
        upd_null = 1'b1;
        wr_acc   = 1'b1;
      end
      alu_exec_pkg::XOR_ACC_WITH_FILE: begin
        res      = acc ^ fval;
        upd_null = 1'b1;
        wr_acc   = ~dest;
        wr_file  = dest;
      end
      default: begin
      end
    endcase
    result_null = (res == 8'h00);
  end

endmodule

// *** dv/tb.sv ***
/*
  Self-checking bench of the execution datapath: a table of operations,
  then refused accesses, watchdog, sleep, wake-up and a second reset.
  Assumes the core answers AXI4-Lite as handed over, on one clock MCLK.
*/
`timescale 1ns/1ps
`include "alu_exec_regs.svh"

module tb;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic        mclk, rst, wake, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, osc_run, asleep;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          n_fail, n_checks;

  typedef struct {
    logic [2:0] op;
    logic       dest;
    logic [6:0] idx;
    logic [7:0] lit;
    logic [7:0] a0;
    logic [7:0] f0;
    logic [7:0] ea;
    logic [7:0] ef;
    logic [2:0] ez;
  } row_s;

  // op, dest, file index, literal, acc before, file before, then acc after,
  // file after and status {null, nibble, borrow} after; flags carry over rows
  row_s rows [13] = '{
    '{3'h0, 1'b0, 7'h00, 8'h00, 8'h05, 8'h05, 8'h00, 8'h05, 3'b111},
    '{3'h0, 1'b1, 7'h7f, 8'h00, 8'h06, 8'h05, 8'h06, 8'hff, 3'b000},
    '{3'h0, 1'b0, 7'h11, 8'h00, 8'h18, 8'h21, 8'h09, 8'h21, 3'b001},
    '{3'h1, 1'b1, 7'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 3'b111},
    '{3'h1, 1'b0, 7'h00, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h00, 3'b001},
    '{3'h1, 1'b0, 7'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 3'b111},
    '{3'h1, 1'b0, 7'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 3'b000},
    '{3'h2, 1'b0, 7'h05, 8'h00, 8'h33, 8'ha5, 8'h5a, 8'ha5, 3'b000},
    '{3'h2, 1'b1, 7'h06, 8'h00, 8'h33, 8'h0f, 8'h33, 8'hf0, 3'b000},
    '{3'h3, 1'b0, 7'h00, 8'h3c, 8'h3c, 8'h00, 8'h00, 8'h00, 3'b100},
    '{3'h3, 1'b1, 7'h00, 8'hf0, 8'h0f, 8'h00, 8'hff, 8'h00, 3'b000},
    '{3'h4, 1'b0, 7'h07, 8'h00, 8'h0f, 8'hf0, 8'hff, 8'hf0, 3'b000},
    '{3'h4, 1'b1, 7'h08, 8'h00, 8'h55, 8'h55, 8'h55, 8'h00, 3'b100}};

  alu_exec_core alu_exec_core_inst (
    .MCLK(mclk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .WAKE(wake), .OSC_RUN(osc_run), .ASLEEP(asleep));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ready is looked at before the edge, since the inputs only move at the edge
  task automatic wr(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] rs);
    bit aw_t, w_t, got;
    @(posedge mclk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rs = 2'bxx;
    for (int k = 0; k < 100 && !got; k++) begin
      @(negedge mclk);
      aw_t = awready;
      w_t = wready;
      if (bvalid) begin
        rs = bresp;
        got = 1'b1;
      end
      @(posedge mclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
    bit tk, got;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rs = 2'bxx;
    dat = 'x;
    for (int k = 0; k < 100 && !got; k++) begin
      @(negedge mclk);
      tk = arready;
      if (rvalid) begin
        dat = rdata;
        rs = rresp;
        got = 1'b1;
      end
      @(posedge mclk);
      if (tk) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(a, v, rs);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY}, {what, " resp"});
    chk(v, exp, what);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run is just over 40k cycles; the watchdog read alone needs 40k
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    $display("[FAIL] t=%0t run did not finish", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, wake, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    do_reset();
    rd_chk(`STATUS_OFS, 32'h18, "status at reset");
    rd_chk(`ACC_OFS, 32'h0, "acc at reset");
    foreach (rows[i]) begin
      wr(`ACC_OFS, {24'h0, rows[i].a0}, r);
      wr(12'h200 + {3'h0, rows[i].idx, 2'h0}, {24'h0, rows[i].f0}, r);
      wr(`INSTR_OFS, {8'h0, rows[i].lit, 5'h0, rows[i].idx, rows[i].dest, rows[i].op}, r);
      rd_chk(`ACC_OFS, {24'h0, rows[i].ea}, "acc");
      rd_chk(12'h200 + {3'h0, rows[i].idx, 2'h0}, {24'h0, rows[i].ef}, "file");
      rd_chk(`STATUS_OFS, {26'h0, 3'b011, rows[i].ez}, "flags");
      $display("row %0d done", i);
    end
    wr(12'h100, 32'h1, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped write");
    wr(`STATUS_OFS, 32'h0, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR}, "status write");
    rd(12'h100, d, r);
    chk({d[29:0], r}, {30'h0, `RESP_SLVERR}, "unmapped read");
    $display("refusal test done");
    repeat (40000) @(posedge mclk);
    rd(`WATCHDOG_OFS, d, r);
    chk({31'h0, d[15:0] != 16'h0}, 32'h1, "watchdog counting");
    wr(`INSTR_OFS, 32'h5, r);
    rd_chk(`STATUS_OFS, {26'h0, 3'b110, rows[12].ez}, "sleep flags");
    rd(`WATCHDOG_OFS, d, r);
    chk({31'h0, d === 32'h0 || d === 32'h100}, 32'h1, "watchdog cleared");
    chk({30'h0, osc_run, asleep}, 32'h1, "asleep pins");
    wr(`INSTR_OFS, 32'hff0003, r);
    rd_chk(`ACC_OFS, {24'h0, rows[12].ea}, "no execute asleep");
    rd_chk(`INSTR_OFS, 32'h5, "instr kept asleep");
    $display("sleep test done");
    wake <= 1'b1;
    for (int k = 0; k < 20 && asleep !== 1'b0; k++) @(posedge mclk);
    wake <= 1'b0;
    chk({31'h0, osc_run}, 32'h1, "awake again");
    wr(`INSTR_OFS, {8'h0, rows[12].ea, 16'h0003}, r);
    rd_chk(`ACC_OFS, 32'h0, "xor after wake");
    rd_chk(`STATUS_OFS, {26'h0, 3'b010, 1'b1, rows[12].ez[1:0]}, "flags after wake");
    wr(`INSTR_OFS, 32'h00ff_0006, r);
    rd_chk(`INSTR_OFS, 32'h00ff_0006, "no-op taken");
    rd_chk(`ACC_OFS, 32'h0, "no-op leaves acc");
    $display("wake test done");
    do_reset();
    rd_chk(`STATUS_OFS, 32'h18, "status after reset");
    rd_chk(`ACC_OFS, 32'h0, "acc after reset");
    $display("second reset test done");
    report_and_stop();
  end
endmodule
